// [tlc_lane_ctrl.sv]
// tlc_lane_ctrl: per-lane transceiver control and status with an
// AHB-Lite register slave and one interrupt line.
// assumes one 10 MHz clock; raw eye-scan and gearbox events are async pins.
`timescale 1ns/1ps
`include "tlc_map.svh"

module tlc_lane_ctrl #(
  parameter int LANES = 12,
  parameter logic [2:0] RX_OUTPUT_DIVIDER_ATTR = 3'h0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [LANES*`TLC_WORD_W-1:0] tx_user_word,
  input wire logic [LANES-1:0] eye_scan_raw_error,
  input wire logic [LANES-1:0] gb_overflow_raw,
  input wire logic [LANES-1:0] gb_underflow_raw,
  output logic [LANES*`TLC_RATE_W-1:0] rx_rate_divider_select,
  output logic [LANES*`TLC_RATE_W-1:0] rx_div_log2,
  output logic [LANES-1:0] tx_lane_invert,
  output logic [LANES*`TLC_WORD_W-1:0] tx_parallel_word,
  output logic [LANES-1:0] eye_scan_error_pulse,
  output logic [2*LANES-1:0] tx_gearbox_fifo_flags,
  output logic irq
);

  localparam int RW = `TLC_RATE_W;
  localparam int PW = `TLC_PSEL_W;
  localparam int WW = `TLC_WORD_W;

  // divider code to log2 of the ratio
  function automatic logic [2:0] div_log2(input logic [2:0] code);
    logic [2:0] r;
    r = `TLC_LOG2_1;
    case (code)
      `TLC_RATE_ATTR: r = RX_OUTPUT_DIVIDER_ATTR;
      `TLC_RATE_D2: r = `TLC_LOG2_2;
      `TLC_RATE_D4: r = `TLC_LOG2_4;
      `TLC_RATE_D8: r = `TLC_LOG2_8;
      `TLC_RATE_D16: r = `TLC_LOG2_16;
      default: r = `TLC_LOG2_1;
    endcase
    return r;
  endfunction : div_log2

  tlc_pkg::tlc_req_s req;
  tlc_pkg::tlc_phase_e phase, next_phase;
  logic [7:0] waddr, next_waddr;
  logic [31:0] next_hrdata;
  logic next_hreadyout;
  logic rd_clr;

  logic [LANES*RW-1:0] next_rate, next_div;
  logic [LANES*PW-1:0] psel, next_psel;
  logic [LANES-1:0] next_invert, inject, next_inject;
  logic [LANES-1:0] arm, next_arm, emask, next_emask, gb_clr;
  logic [`TLC_ST_W-1:0] st, next_st, imask, next_imask, ev;
  logic [2*LANES-1:0] next_gbf;
  logic [LANES-1:0] next_eye, ov_new, un_new;
  logic [LANES*WW-1:0] next_txw;
  logic [LANES-1:0][WW-1:0] lfsr, next_lfsr;
  logic next_irq;

  logic [LANES-1:0] es1, es2, es3, ov1, ov2, un1, un2;

  // two-stage synchronisers; es3 only delays es2 for the edge detect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      es1 <= '0;
      es2 <= '0;
      es3 <= '0;
      ov1 <= '0;
      ov2 <= '0;
      un1 <= '0;
      un2 <= '0;
    end else begin
      es1 <= eye_scan_raw_error;
      es2 <= es1;
      es3 <= es2;
      ov1 <= gb_overflow_raw;
      ov2 <= ov1;
      un1 <= gb_underflow_raw;
      un2 <= un1;
    end
  end

  // address phase decode; writes take one wait state
  always_comb begin
    req.valid = hsel & hready & (htrans == `TLC_HTRANS_NONSEQ);
    req.write = hwrite;
    req.addr = haddr[7:0];
    next_phase = tlc_pkg::TLC_PH_IDLE;
    next_waddr = waddr;
    next_hreadyout = 1'b1;
    next_hrdata = hrdata;
    rd_clr = 1'b0;
    if (req.valid && req.write) begin
      next_phase = tlc_pkg::TLC_PH_WRITE;
      next_waddr = req.addr;
      next_hreadyout = 1'b0;
    end else if (req.valid) begin
      next_hrdata = `TLC_RST_WORD;
      case (req.addr)
        `TLC_OFF_RATE_LO:
          next_hrdata[`TLC_RATE_LO_BITS-1:0] =
            rx_rate_divider_select[`TLC_RATE_LO_BITS-1:0];
        `TLC_OFF_RATE_HI:
          next_hrdata[LANES*RW-`TLC_RATE_LO_BITS-1:0] =
            rx_rate_divider_select[LANES*RW-1:`TLC_RATE_LO_BITS];
        `TLC_OFF_INVERT: next_hrdata[LANES-1:0] = tx_lane_invert;
        `TLC_OFF_PSEL_LO: next_hrdata = psel[`TLC_PSEL_LO_BITS-1:0];
        `TLC_OFF_PSEL_HI:
          next_hrdata[LANES*PW-`TLC_PSEL_LO_BITS-1:0] =
            psel[LANES*PW-1:`TLC_PSEL_LO_BITS];
        `TLC_OFF_INJECT: next_hrdata[LANES-1:0] = inject;
        `TLC_OFF_ES_ARM: next_hrdata[LANES-1:0] = arm;
        `TLC_OFF_ES_MASK: next_hrdata[LANES-1:0] = emask;
        `TLC_OFF_GB_FLAGS: next_hrdata[2*LANES-1:0] = tx_gearbox_fifo_flags;
        `TLC_OFF_IRQ_ST: begin
          next_hrdata[`TLC_ST_W-1:0] = st;
          rd_clr = 1'b1;
        end
        `TLC_OFF_IRQ_MASK: next_hrdata[`TLC_ST_W-1:0] = imask;
        default: next_hrdata = `TLC_RST_WORD;
      endcase
    end
  end

  // register writes land in the wait cycle of the data phase
  always_comb begin
    next_rate = rx_rate_divider_select;
    next_invert = tx_lane_invert;
    next_psel = psel;
    next_inject = inject;
    next_arm = arm;
    next_emask = emask;
    next_imask = imask;
    gb_clr = '0;
    if (phase == tlc_pkg::TLC_PH_WRITE) begin
      case (waddr)
        `TLC_OFF_RATE_LO:
          next_rate[`TLC_RATE_LO_BITS-1:0] = hwdata[`TLC_RATE_LO_BITS-1:0];
        `TLC_OFF_RATE_HI:
          next_rate[LANES*RW-1:`TLC_RATE_LO_BITS] =
            hwdata[LANES*RW-`TLC_RATE_LO_BITS-1:0];
        `TLC_OFF_INVERT: next_invert = hwdata[LANES-1:0];
        `TLC_OFF_PSEL_LO: next_psel[`TLC_PSEL_LO_BITS-1:0] = hwdata;
        `TLC_OFF_PSEL_HI:
          next_psel[LANES*PW-1:`TLC_PSEL_LO_BITS] =
            hwdata[LANES*PW-`TLC_PSEL_LO_BITS-1:0];
        `TLC_OFF_INJECT: next_inject = hwdata[LANES-1:0];
        `TLC_OFF_ES_ARM: next_arm = hwdata[LANES-1:0];
        `TLC_OFF_ES_MASK: next_emask = hwdata[LANES-1:0];
        `TLC_OFF_GB_RESET: gb_clr = hwdata[LANES-1:0];
        `TLC_OFF_IRQ_MASK: next_imask = hwdata[`TLC_ST_W-1:0];
        default: gb_clr = '0;
      endcase
    end
  end

  // per-lane datapath and status
  always_comb begin
    next_div = '0;
    next_txw = '0;
    next_eye = '0;
    next_gbf = '0;
    next_lfsr = lfsr;
    ov_new = '0;
    un_new = '0;
    for (int i = 0; i < LANES; i++) begin
      // RULE1 divider decode; RULE9 slice per lane
      next_div[i*RW +: RW] = div_log2(rx_rate_divider_select[i*RW +: RW]);
      next_lfsr[i] = {lfsr[i][WW-2:0],
                      ^(lfsr[i] & `TLC_PRBS_TAPS)};
      // RULE3 RULE4 inject only on pattern
      if (psel[i*PW +: PW] == `TLC_PSEL_OFF)
        next_txw[i*WW +: WW] = tx_user_word[i*WW +: WW];
      else
        next_txw[i*WW +: WW] = lfsr[i] ^ {{(WW-1){1'b0}}, inject[i]};
      // RULE2 lane inversion
      next_txw[i*WW +: WW] = next_txw[i*WW +: WW] ^ {WW{tx_lane_invert[i]}};
      // RULE5 one pulse per armed unmasked error
      next_eye[i] = es2[i] & ~es3[i] & arm[i] & ~emask[i];
      ov_new[i] = ov2[i] & ~tx_gearbox_fifo_flags[2*i+`TLC_GB_OVF];
      un_new[i] = un2[i] & ~tx_gearbox_fifo_flags[2*i+`TLC_GB_UNF];
      // RULE6 RULE7 RULE8 sticky until gearbox reset, set wins
      next_gbf[2*i+`TLC_GB_OVF] = ov2[i] |
        (tx_gearbox_fifo_flags[2*i+`TLC_GB_OVF] & ~gb_clr[i]);
      next_gbf[2*i+`TLC_GB_UNF] = un2[i] |
        (tx_gearbox_fifo_flags[2*i+`TLC_GB_UNF] & ~gb_clr[i]);
    end
    ev = {|un_new, |ov_new, next_eye};
    next_st = (rd_clr ? '0 : st) | ev;
    next_irq = |(next_st & next_imask);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= tlc_pkg::TLC_PH_IDLE;
      waddr <= '0;
      hrdata <= `TLC_RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      rx_rate_divider_select <= '0;
      rx_div_log2 <= '0;
      tx_lane_invert <= '0;
      psel <= '0;
      inject <= '0;
      arm <= '0;
      emask <= '0;
      imask <= '0;
      st <= '0;
      irq <= 1'b0;
      tx_gearbox_fifo_flags <= '0;
      eye_scan_error_pulse <= '0;
      tx_parallel_word <= '0;
      lfsr <= {LANES{`TLC_PRBS_SEED}};
    end else begin
      phase <= next_phase;
      waddr <= next_waddr;
      hrdata <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      rx_rate_divider_select <= next_rate;
      rx_div_log2 <= next_div;
      tx_lane_invert <= next_invert;
      psel <= next_psel;
      inject <= next_inject;
      arm <= next_arm;
      emask <= next_emask;
      imask <= next_imask;
      st <= next_st;
      irq <= next_irq;
      tx_gearbox_fifo_flags <= next_gbf;
      eye_scan_error_pulse <= next_eye;
      tx_parallel_word <= next_txw;
      lfsr <= next_lfsr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rate_div_map_a: assert property ( // RULE1
    $past(resetn) |->
      rx_div_log2[2:0] == div_log2($past(rx_rate_divider_select[2:0])))
    else $error("lane 0 divider decode wrong");

  last_lane_slice_a: assert property ( // RULE9
    ($past(rx_rate_divider_select[LANES*RW-1 -: RW]) == `TLC_RATE_D16)
      |-> rx_div_log2[LANES*RW-1 -: RW] == `TLC_LOG2_16)
    else $error("last lane slice misplaced");

  lane_invert_a: assert property ( // RULE2
    $past(resetn) && ($past(psel[PW-1:0]) == `TLC_PSEL_OFF)
      |-> tx_parallel_word[WW-1:0] ==
          ($past(tx_user_word[WW-1:0]) ^ {WW{$past(tx_lane_invert[0])}}))
    else $error("lane 0 inversion wrong");

  inject_corrupt_a: assert property ( // RULE3
    ($past(psel[PW-1:0]) != `TLC_PSEL_OFF) && $past(inject[0])
      |-> tx_parallel_word[0] !=
          ($past(lfsr[0][0]) ^ $past(tx_lane_invert[0])))
    else $error("injected error missing");

  inject_ignored_a: assert property ( // RULE4
    ($past(psel[PW-1:0]) == `TLC_PSEL_OFF) && $past(inject[0])
      |-> tx_parallel_word[0] ==
          ($past(tx_user_word[0]) ^ $past(tx_lane_invert[0])))
    else $error("inject touched user word");

  eye_pulse_a: assert property ( // RULE5
    eye_scan_error_pulse[0]
      |-> $past(arm[0]) && !$past(emask[0]) ##1 !eye_scan_error_pulse[0])
    else $error("eye pulse unarmed or too long");

  gb_ovf_set_a: assert property ( // RULE6
    $past(ov2[0]) |-> tx_gearbox_fifo_flags[`TLC_GB_OVF])
    else $error("overflow flag not set");

  gb_unf_set_a: assert property ( // RULE7
    $past(un2[0]) |-> tx_gearbox_fifo_flags[`TLC_GB_UNF])
    else $error("underflow flag not set");

  gb_sticky_a: assert property ( // RULE8
    tx_gearbox_fifo_flags[`TLC_GB_OVF] && !gb_clr[0]
      |=> tx_gearbox_fifo_flags[`TLC_GB_OVF])
    else $error("overflow flag dropped without reset");

  irq_level_a: assert property (
    (|(st & imask)) |-> irq)
    else $error("interrupt not raised");

endmodule : tlc_lane_ctrl

// [tlc_map.svh]
// tlc_map.svh: register offsets, field widths, codes and reset values
// for the lane control block; included by the block and its bench.
//
// Overview of operation
// RULE1: rate code 0 uses attribute; 1-5 divide 1 to 16; 6 and 7 divide 1.
// RULE2: lane invert bit high complements that lane's outgoing word.
// RULE3: error inject held high corrupts that lane's test pattern while held.
// RULE4: pattern select zero: error inject leaves the sent word alone.
// RULE5: eye-scan error pulses one cycle per unmasked error while armed.
// RULE6: gearbox flags bit 1 reads 1 after transmit gearbox FIFO overflow.
// RULE7: gearbox flags bit 0 reads 1 after transmit gearbox FIFO underflow.
// RULE8: gearbox flags stay high until that lane's gearbox is reset.
// RULE9: per-lane buses packed lane by lane, lane n in the n-th slice.
`ifndef TLC_MAP_SVH
`define TLC_MAP_SVH

`define TLC_OFF_RATE_LO 8'h00
`define TLC_OFF_RATE_HI 8'h04
`define TLC_OFF_INVERT 8'h08
`define TLC_OFF_PSEL_LO 8'h0C
`define TLC_OFF_PSEL_HI 8'h10
`define TLC_OFF_INJECT 8'h14
`define TLC_OFF_ES_ARM 8'h18
`define TLC_OFF_ES_MASK 8'h1C
`define TLC_OFF_GB_FLAGS 8'h20
`define TLC_OFF_GB_RESET 8'h24
`define TLC_OFF_IRQ_ST 8'h28
`define TLC_OFF_IRQ_MASK 8'h2C

`define TLC_RATE_LO_BITS 30
`define TLC_PSEL_LO_BITS 32
`define TLC_RATE_W 3
`define TLC_PSEL_W 4
`define TLC_WORD_W 16
`define TLC_ST_W 14
`define TLC_ST_OVF 12
`define TLC_ST_UNF 13
`define TLC_GB_OVF 1
`define TLC_GB_UNF 0

`define TLC_RATE_ATTR 3'h0
`define TLC_RATE_D1 3'h1
`define TLC_RATE_D2 3'h2
`define TLC_RATE_D4 3'h3
`define TLC_RATE_D8 3'h4
`define TLC_RATE_D16 3'h5
`define TLC_LOG2_1 3'h0
`define TLC_LOG2_2 3'h1
`define TLC_LOG2_4 3'h2
`define TLC_LOG2_8 3'h3
`define TLC_LOG2_16 3'h4

`define TLC_PSEL_OFF 4'h0
`define TLC_PRBS_SEED 16'hACE1
`define TLC_PRBS_TAPS 16'hB400
`define TLC_HTRANS_NONSEQ 2'h2
`define TLC_RST_WORD 32'h0000_0000

`endif

// [tlc_pkg.sv]
// tlc_pkg: types shared by the lane control block.
// assumes the constants of tlc_map.svh for widths.
package tlc_pkg;

  typedef enum {TLC_PH_IDLE, TLC_PH_WRITE} tlc_phase_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } tlc_req_s;

endpackage : tlc_pkg

// [tlc_user_model.sv]
// tlc_user_model: user logic beside the lane block.
// assumes the bench requests raw events just after a clock edge.
`timescale 1ns/1ps
module tlc_user_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] eye_req,
  input wire logic [11:0] ovf_req,
  input wire logic [11:0] unf_req,
  output logic [191:0] tx_user_word,
  output logic [11:0] eye_scan_raw_error,
  output logic [11:0] gb_overflow_raw,
  output logic [11:0] gb_underflow_raw
);
  always_comb begin
    for (int n = 0; n < 12; n++) begin
      tx_user_word[16*n +: 16] = 16'h5A00 | 16'(n);
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eye_scan_raw_error <= 12'h000;
      gb_overflow_raw <= 12'h000;
      gb_underflow_raw <= 12'h000;
    end else begin
      eye_scan_raw_error <= eye_req;
      gb_overflow_raw <= ovf_req;
      gb_underflow_raw <= unf_req;
    end
  end
endmodule : tlc_user_model

// [tb_tlc_lane_ctrl.sv]
// tb_tlc_lane_ctrl: register-driven tests of the lane block.
// assumes the default of 12 lanes and divider attribute 0.
`timescale 1ns/1ps
`include "tlc_map.svh"
module tb_tlc_lane_ctrl;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [191:0] user, txw;
  logic [35:0] rate, lg2;
  logic [11:0] inv, pulse, eye_req, ovf_req, unf_req, e_raw, o_raw, u_raw;
  logic [23:0] flags;
  logic [2:0] lg [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
  int errors = 0, total_checks = 0, cycles = 0, c0, c2, c3;

  tlc_lane_ctrl tlc_lane_ctrl_i (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_user_word(user),
    .eye_scan_raw_error(e_raw), .gb_overflow_raw(o_raw),
    .gb_underflow_raw(u_raw), .rx_rate_divider_select(rate),
    .rx_div_log2(lg2), .tx_lane_invert(inv), .tx_parallel_word(txw),
    .eye_scan_error_pulse(pulse), .tx_gearbox_fifo_flags(flags), .irq(irq));
  tlc_user_model tlc_user_model_i (.clk(clk), .resetn(resetn),
    .eye_req(eye_req), .ovf_req(ovf_req), .unf_req(unf_req),
    .tx_user_word(user), .eye_scan_raw_error(e_raw),
    .gb_overflow_raw(o_raw), .gb_underflow_raw(u_raw));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one single transfer; every change just after a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= `TLC_HTRANS_NONSEQ;
    hsel <= 1'b1;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : xfer

  task rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rchk

  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    {eye_req, ovf_req, unf_req} = '0;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk(`TLC_OFF_GB_FLAGS, 32'h0);
    rchk(8'h40, 32'h0);
    chk("hresp", 32'h0, 32'(hresp));
    chk("irq reset", 32'h0, 32'(irq));
    $display("test reset done");
    d = 32'h0;
    for (int n = 0; n < 8; n++) d[3*n +: 3] = 3'(n);
    xfer(1'b1, `TLC_OFF_RATE_LO, d);
    xfer(1'b1, `TLC_OFF_RATE_HI, 32'h2D);
    repeat (2) @(negedge clk);
    for (int n = 0; n < 8; n++) begin
      chk("rate", 32'(n), 32'(rate[3*n +: 3]));
      chk("log2", 32'(lg[n]), 32'(lg2[3*n +: 3]));
    end
    chk("rate hi", 32'h2D, 32'(rate[35:30]));
    rchk(`TLC_OFF_RATE_LO, d);
    $display("test rate done");
    xfer(1'b1, `TLC_OFF_PSEL_LO, 32'h11);
    xfer(1'b1, `TLC_OFF_INJECT, 32'h1);
    repeat (3) @(negedge clk);
    chk("inject", 32'h1, 32'(txw[15:0] ^ txw[31:16]));
    xfer(1'b1, `TLC_OFF_PSEL_LO, 32'h0);
    xfer(1'b1, `TLC_OFF_INJECT, 32'hFFF);
    xfer(1'b1, `TLC_OFF_INVERT, 32'h1);
    repeat (3) @(negedge clk);
    chk("invert pin", 32'h1, 32'(inv));
    chk("lane0", 32'(user[15:0] ^ 16'hFFFF), 32'(txw[15:0]));
    chk("lane1", 32'(user[31:16]), 32'(txw[31:16]));
    $display("test datapath done");
    xfer(1'b1, `TLC_OFF_ES_ARM, 32'h9);
    xfer(1'b1, `TLC_OFF_ES_MASK, 32'h8);
    xfer(1'b1, `TLC_OFF_IRQ_MASK, 32'h1);
    eye_req <= 12'h00D;
    c0 = 0;
    c2 = 0;
    c3 = 0;
    repeat (12) begin
      @(negedge clk);
      c0 += int'(pulse[0] === 1'b1);
      c2 += int'(pulse[2] === 1'b1);
      c3 += int'(pulse[3] === 1'b1);
    end
    chk("pulse armed", 32'h1, 32'(c0));
    chk("pulse unarmed", 32'h0, 32'(c2));
    chk("pulse masked", 32'h0, 32'(c3));
    chk("irq", 32'h1, 32'(irq));
    @(posedge clk);
    eye_req <= 12'h000;
    rchk(`TLC_OFF_IRQ_ST, 32'h1);
    rchk(`TLC_OFF_IRQ_ST, 32'h0);
    @(negedge clk);
    chk("irq clear", 32'h0, 32'(irq));
    $display("test eye scan done");
    @(posedge clk);
    ovf_req <= 12'h003;
    repeat (2) @(posedge clk);
    ovf_req <= 12'h000;
    repeat (8) @(posedge clk);
    rchk(`TLC_OFF_GB_FLAGS, 32'hA);
    unf_req <= 12'h003;
    repeat (2) @(posedge clk);
    unf_req <= 12'h000;
    repeat (8) @(posedge clk);
    rchk(`TLC_OFF_GB_FLAGS, 32'hF);
    chk("flags pin", 32'hF, 32'(flags));
    rchk(`TLC_OFF_IRQ_ST, 32'h3000);
    xfer(1'b1, `TLC_OFF_GB_RESET, 32'h3);
    repeat (2) @(posedge clk);
    rchk(`TLC_OFF_GB_FLAGS, 32'h0);
    $display("test gearbox done");
    finish_test();
  end
endmodule : tb_tlc_lane_ctrl
